// file: common/pwm8_pkg.sv
package pwm8_pkg;

  // Channel count and data widths
  localparam int NUM_CH = 8;
  localparam int DUTY_W = 8;
  localparam int NIB_W = 4;
  localparam int ADDR_W = 8;
  localparam int PRESCALE_W = 12;

  // Register byte offsets on the APB window
  localparam logic [ADDR_W-1:0] OFF_SELECT = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_DUTY = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_POLARITY = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_OUT_EN = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_PCLK = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_STC = 8'h14;

  // Field positions in the clock and channel select register
  localparam int SEL_CKE_BIT = 7;
  localparam int SEL_CKS_BIT = 6;
  localparam int SEL_ONE_BIT = 5;
  localparam int SEL_ZERO_BIT = 4;
  localparam int SEL_RS_MSB = 3;

  // Field positions in the peripheral clock choice register
  localparam int PCLK_C_BIT = 3;
  localparam int PCLK_B_BIT = 2;
  localparam int PCLK_A_BIT = 1;

  // Field position of the flash access enable in the serial timer control
  localparam int STC_FLASH_BIT = 3;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_RS = 4'h0;
  localparam logic [7:0] SEL_FIXED_READ = 8'h20;

  // Prescaler shift amounts (log2 of the division)
  localparam logic [3:0] SH_DIV1 = 4'h0;
  localparam logic [3:0] SH_DIV2 = 4'h1;
  localparam logic [3:0] SH_DIV4 = 4'h2;
  localparam logic [3:0] SH_DIV8 = 4'h3;
  localparam logic [3:0] SH_DIV16 = 4'h4;
  localparam logic [3:0] SH_DIV256 = 4'h8;
  localparam logic [3:0] SH_DIV512 = 4'h9;
  localparam logic [3:0] SH_DIV1024 = 4'ha;
  localparam logic [3:0] SH_DIV4096 = 4'hc;

  // Last resolution step inside one basic pulse
  localparam logic [NIB_W-1:0] LAST_STEP = 4'hf;

  // Bus handshake states
  typedef enum logic [1:0] {BUS_IDLE, BUS_FETCH, BUS_ANSWER} bus_state_t;

  // Clock and channel select register contents
  typedef struct packed {
    logic cke;
    logic cks;
    logic [3:0] rs;
  } select_reg_t;

  // Peripheral clock choice bits
  typedef struct packed {
    logic c;
    logic b;
    logic a;
  } pclk_reg_t;

endpackage

// file: logic/duty_bank.sv
`timescale 1ns/1ns
`default_nettype none

// Small register bank: one write port, one registered read port,
// and every word visible in parallel for the waveform logic.
module duty_bank #(
  parameter int WORDS = 8,
  parameter int WIDTH = 8
) (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Write port
  input wire logic wr_en,
  input wire logic [$clog2(WORDS)-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // Read port
  input wire logic [$clog2(WORDS)-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data,
  // Parallel view
  output logic [WORDS-1:0][WIDTH-1:0] words
);

  initial begin
    if (WORDS < 2 || WIDTH < 1) begin
      $error("duty_bank: WORDS must be at least 2 and WIDTH at least 1");
    end
  end

  // Whole state of the bank
  typedef struct packed {
    logic [WORDS-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0] rd;
  } bank_t;

  bank_t st;
  bank_t next_st;

  // Read data always comes out of a register
  always_comb begin
    next_st = st;
    next_st.rd = st.mem[rd_addr];
    if (wr_en) begin
      next_st.mem[wr_addr] = wr_data;
    end
  end

  // Registered state, frozen while the enable is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign rd_data = st.rd;
  assign words = st.mem;

endmodule // duty_bank

`default_nettype wire

// file: logic/pwm8_timer.sv
// Our own choices: the address map and the APB slave port.
`timescale 1ns/1ns
`default_nettype none

module pwm8_timer
  import pwm8_pkg::*;
#(
  parameter int CHANNELS = NUM_CH
) (
  // Clock, reset, clock enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Port data and direction from the shared port
  input wire logic [CHANNELS-1:0] port_data,
  input wire logic [CHANNELS-1:0] port_dir,
  // Pulse pins
  output logic [CHANNELS-1:0] pulse_output_pins,
  output logic [CHANNELS-1:0] pin_oe_n
);

  // The select field addresses at most eight channels
  initial begin
    if (CHANNELS < 2 || CHANNELS > NUM_CH) begin
      $error("pwm8_timer: CHANNELS must lie between 2 and 8");
    end
  end

  // Width of the channel index on the bank ports; codes past the last
  // channel are caught by sel_valid, never by the bank itself
  localparam int CH_AW = $clog2(CHANNELS);

  // Whole state of the timer: one struct, so one registered copy
  // freezes everything at once when the clock enable drops
  typedef struct packed {
    bus_state_t bus;                          // Handshake phase
    logic [31:0] rdata;                       // Read data held for the answer
    logic ready;                              // Access completes this cycle
    logic err;                                // Unmapped address flag
    select_reg_t sel;                         // Clock and channel select
    pclk_reg_t pclk_sel;                      // Peripheral clock choice
    logic flash_en;                           // Flash access enable
    logic [CHANNELS-1:0] invert;              // Output phase invert
    logic [CHANNELS-1:0] drive_en;            // Waveform enable; low passes port data, pin drive follows port_dir
    logic [PRESCALE_W-1:0] prescale;          // Free division counter
    logic [DUTY_W-1:0] timebase;              // Shared time base counter
    logic [CHANNELS-1:0] pin_level;           // Registered pin level
    logic [CHANNELS-1:0] pin_oen;             // Registered pin enable, low drives
  } timer_t;

  timer_t st;
  timer_t next_st;

  // Duty bank interface
  logic duty_we;                              // Bank write strobe
  logic [DUTY_W-1:0] duty_rd;                 // Selected word, registered
  logic [CHANNELS-1:0][DUTY_W-1:0] duty_all;  // All words in parallel

  // Map the clock select and peripheral bits to a prescale shift
  // Select low: {c,b,a} picks phi, /2, /4, /8, or /16 for any 1xx code
  // Select high: {c,b} picks /256, /512, /1024 or /4096; a is ignored
  // A shift instead of a divider lets one prescaler serve every rate
  function automatic logic [3:0] rate_shift(input select_reg_t s,
                                           input pclk_reg_t p);
    logic [3:0] sh;
    sh = SH_DIV1;
    if (!s.cks) begin
      case ({p.c, p.b, p.a})
        3'h0: sh = SH_DIV1;
        3'h1: sh = SH_DIV2;
        3'h2: sh = SH_DIV4;
        3'h3: sh = SH_DIV8;
        default: sh = SH_DIV16;
      endcase
    end else begin
      case ({p.c, p.b})
        2'h0: sh = SH_DIV256;
        2'h1: sh = SH_DIV512;
        2'h2: sh = SH_DIV1024;
        default: sh = SH_DIV4096;
      endcase
    end
    return sh;
  endfunction

  // True when the prescaler completes one division of the given size
  // The prescaler restarts at zero on enable, so the first tick comes
  // one full division after the enable bit is set
  function automatic logic division_done(input logic [PRESCALE_W-1:0] cnt,
                                         input logic [3:0] sh);
    logic [PRESCALE_W-1:0] mask;
    mask = (PRESCALE_W'(1) << sh) - PRESCALE_W'(1);
    return (cnt & mask) == mask;
  endfunction

  // Reverse a nibble, used to spread extra pulses evenly
  // A count of 8 then lands on every other basic pulse, 4 on every
  // fourth, which keeps the ripple after the filter small
  function automatic logic [NIB_W-1:0] nib_reverse(input logic [NIB_W-1:0] v);
    return {v[0], v[1], v[2], v[3]};
  endfunction

  // Active level of one channel for a given time base position
  // The extra step is step 15 of the pulse before the one it serves,
  // right ahead of that pulse's rising edge, even with no basic duty
  function automatic logic active_level(input logic [DUTY_W-1:0] duty,
                                        input logic [DUTY_W-1:0] tb);
    logic [NIB_W-1:0] step;
    logic [NIB_W-1:0] next_pulse;
    logic basic;
    logic extra;
    step = tb[NIB_W-1:0];
    next_pulse = tb[DUTY_W-1:NIB_W] + NIB_W'(1);
    basic = step < duty[DUTY_W-1:NIB_W];
    extra = (step == LAST_STEP) &&
            (nib_reverse(next_pulse) < duty[NIB_W-1:0]);
    return basic | extra;
  endfunction

  // Bus decode helpers
  logic setup_phase;                          // First cycle of a transfer
  logic commit;                               // Edge at which the access ends
  logic sel_valid;                            // Select names a channel
  logic mapped;                               // Address is one of ours
  logic [DUTY_W-1:0] sel_read;                // Select register read view
  logic [DUTY_W-1:0] pclk_read;               // Clock choice read view
  logic [3:0] shift;                          // Current prescale shift
  logic tick;                                 // One time base step

  // Writes and the bank strobe act only where the master sees pready,
  // so a transfer can never land twice
  assign setup_phase = psel && !penable;
  assign commit = psel && penable && st.ready && (st.bus == BUS_ANSWER);
  assign sel_valid = !st.sel.rs[SEL_RS_MSB] &&
                     (int'(st.sel.rs) < CHANNELS);
  assign mapped = (paddr == OFF_SELECT) || (paddr == OFF_DUTY) ||
                  (paddr == OFF_POLARITY) || (paddr == OFF_OUT_EN) ||
                  (paddr == OFF_PCLK) || (paddr == OFF_STC);
  assign shift = rate_shift(st.sel, st.pclk_sel);
  assign tick = st.sel.cke && division_done(st.prescale, shift);

  // Select register read view with its fixed bits
  // Bits 5 and 4 come from the constant only, so they cannot drift
  always_comb begin
    sel_read = SEL_FIXED_READ;
    sel_read[SEL_CKE_BIT] = st.sel.cke;
    sel_read[SEL_CKS_BIT] = st.sel.cks;
    sel_read[SEL_RS_MSB:0] = st.sel.rs;
  end

  // Clock choice read view; reserved bits stay zero
  // Bits 7 to 4 and bit 0 hold nothing, so writes to them are lost
  always_comb begin
    pclk_read = RST_BYTE;
    pclk_read[PCLK_C_BIT] = st.pclk_sel.c;
    pclk_read[PCLK_B_BIT] = st.pclk_sel.b;
    pclk_read[PCLK_A_BIT] = st.pclk_sel.a;
  end

  // Bank writes land only at the completing edge of a valid duty access
  assign duty_we = commit && pwrite && (paddr == OFF_DUTY) && sel_valid;

  duty_bank #(
    .WORDS(CHANNELS),
    .WIDTH(DUTY_W)
  ) u_duty (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .wr_en(duty_we),
    .wr_addr(st.sel.rs[CH_AW-1:0]),
    .wr_data(pwdata[DUTY_W-1:0]),
    .rd_addr(st.sel.rs[CH_AW-1:0]),
    .rd_data(duty_rd),
    .words(duty_all)
  );

  // Next-state logic: bus handshake, registers, time base and pins
  always_comb begin
    next_st = st;

    // Handshake: setup, fetch read data, answer with ready
    // Always one wait state: the bank word for the current select is
    // already registered by the fetch cycle, so no longer wait is needed
    case (st.bus)
      BUS_IDLE: begin
        if (setup_phase) begin
          next_st.bus = BUS_FETCH;
        end
      end
      BUS_FETCH: begin
        // Read data settles here; the bank word was fetched at setup
        next_st.rdata = '0;
        next_st.err = !mapped;
        next_st.ready = 1'b1;
        next_st.bus = BUS_ANSWER;
        if (!pwrite) begin
          case (paddr)
            OFF_SELECT: next_st.rdata[DUTY_W-1:0] = sel_read;
            OFF_DUTY: begin
              if (sel_valid) begin
                next_st.rdata[DUTY_W-1:0] = duty_rd;
              end
            end
            OFF_POLARITY: next_st.rdata[CHANNELS-1:0] = st.invert;
            OFF_OUT_EN: next_st.rdata[CHANNELS-1:0] = st.drive_en;
            OFF_PCLK: begin
              // Reads as zero while the flash access enable is set
              if (!st.flash_en) begin
                next_st.rdata[DUTY_W-1:0] = pclk_read;
              end
            end
            OFF_STC: next_st.rdata[STC_FLASH_BIT] = st.flash_en;
            default: next_st.rdata = '0;
          endcase
        end
      end
      BUS_ANSWER: begin
        // Ready stands for exactly one access cycle
        next_st.ready = 1'b0;
        next_st.err = 1'b0;
        next_st.bus = BUS_IDLE;
      end
      default: begin
        next_st.bus = BUS_IDLE;
        next_st.ready = 1'b0;
      end
    endcase

    // Register writes take effect at the completing edge only
    // An unmapped offset only raises the error flag; nothing is stored,
    // and the duty bank is written through its own strobe above
    if (commit && pwrite) begin
      case (paddr)
        OFF_SELECT: begin
          // Fixed bits 5 and 4 are not stored, so writes to them vanish
          next_st.sel.cke = pwdata[SEL_CKE_BIT];
          next_st.sel.cks = pwdata[SEL_CKS_BIT];
          next_st.sel.rs = pwdata[SEL_RS_MSB:0];
        end
        OFF_POLARITY: next_st.invert = pwdata[CHANNELS-1:0];
        OFF_OUT_EN: next_st.drive_en = pwdata[CHANNELS-1:0];
        OFF_PCLK: begin
          if (!st.flash_en) begin
            next_st.pclk_sel.c = pwdata[PCLK_C_BIT];
            next_st.pclk_sel.b = pwdata[PCLK_B_BIT];
            next_st.pclk_sel.a = pwdata[PCLK_A_BIT];
          end
        end
        OFF_STC: next_st.flash_en = pwdata[STC_FLASH_BIT];
        default: next_st.flash_en = st.flash_en;
      endcase
    end

    // Prescaler runs only while enabled, so each enable starts aligned
    if (st.sel.cke) begin
      next_st.prescale = st.prescale + PRESCALE_W'(1);
    end else begin
      next_st.prescale = '0;
    end

    // One shared 8-bit time base; wraps every 256 steps
    if (tick) begin
      next_st.timebase = st.timebase + DUTY_W'(1);
    end

    // Pin levels: waveform or port data, phase set per channel
    for (int ch = 0; ch < CHANNELS; ch++) begin
      if (st.drive_en[ch]) begin
        // Polarity is applied last, so inversion swaps high and low widths
        next_st.pin_level[ch] =
          active_level(duty_all[ch], st.timebase) ^ st.invert[ch];
      end else begin
        // Full-on output is the port's job; this block passes its data
        next_st.pin_level[ch] = port_data[ch];
      end
      // The enable follows the direction bit whatever the drive enable says,
      // so a channel set to port data drives its pin whenever its direction bit is set
      next_st.pin_oen[ch] = !port_dir[ch];
    end
  end

  // Registered state, frozen while the clock enable is low
  // Reset spells the fields out: the pins come up undriven and the time
  // base stopped, and read data starts at zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st.bus <= BUS_IDLE;
      st.rdata <= '0;
      st.ready <= 1'b0;
      st.err <= 1'b0;
      st.sel <= '{cke: 1'b0, cks: 1'b0, rs: RST_RS};
      st.pclk_sel <= '0;
      st.flash_en <= 1'b0;
      st.invert <= '0;
      st.drive_en <= '0;
      st.prescale <= '0;
      st.timebase <= '0;
      st.pin_level <= '0;
      st.pin_oen <= '1;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // Every output comes straight from the state register
  // No output passes through logic, so the bus and pins see clean edges
  assign prdata = st.rdata;
  assign pready = st.ready;
  assign pslverr = st.err;
  assign pulse_output_pins = st.pin_level;
  assign pin_oe_n = st.pin_oen;

endmodule // pwm8_timer

`default_nettype wire

// file: sim/lpf_model.sv
`timescale 1ns/1ns
`default_nettype none

// External low-pass filter, reduced to an integrator of the pin level
module lpf_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Filtered pin and window restart
  input wire logic pin,
  input wire logic clear,
  // Charge, counted in active cycles
  output logic [19:0] charge
);
  // An unknown pin poisons the sum, which is what we want to notice
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      charge <= 20'h00000;
    end else if (clear) begin
      charge <= 20'h00000;
    end else begin
      charge <= charge + {19'h00000, pin};
    end
  end
endmodule // lpf_model

`default_nettype wire

// file: sim/pwm8_chk.sv
`timescale 1ns/1ns
`default_nettype none

// Port-level watcher for the bus handshake, read data and pin enables
module pwm8_chk
  import pwm8_pkg::*;
#(
  parameter int CHANNELS = NUM_CH
) (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Bus side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pin side
  input wire logic [CHANNELS-1:0] port_dir,
  input wire logic [CHANNELS-1:0] pin_oe_n
);
  default clocking @(posedge pclk); endclocking
  // A frozen clock enable stalls everything, so checking pauses too
  default disable iff (!presetn || !ce);

  // Offsets that answer without error
  logic mapped;
  assign mapped = paddr inside {OFF_SELECT, OFF_DUTY, OFF_POLARITY, OFF_OUT_EN, OFF_PCLK, OFF_STC};

  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready stood longer than one cycle");
  a_ready_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("pready not after exactly one wait state");
  a_ready_phase: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  a_err_decode: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr does not match address decode");
  a_err_data: assert property (pready && !pwrite && pslverr |-> prdata == 32'h00000000)
    else $error("failed read returned data");
  a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h000000)
    else $error("read data wider than a byte");
  a_sel_fixed: assert property (pready && !pwrite && paddr == OFF_SELECT
    |-> prdata[5:4] == 2'b10)
    else $error("fixed select bits read wrong");
  a_pclk_res: assert property (pready && !pwrite && paddr == OFF_PCLK
    |-> prdata[7:4] == 4'h0 && !prdata[0])
    else $error("reserved clock choice bits read set");
  a_oe_track: assert property ($past(presetn) |=> pin_oe_n == ~$past(port_dir))
    else $error("pin enable does not follow direction");

  // Main traffic kinds
  c_write: cover property (pready && pwrite && !pslverr);
  c_read: cover property (pready && !pwrite && !pslverr);
  c_error: cover property (pready && pslverr);
endmodule // pwm8_chk

bind pwm8_timer pwm8_chk #(.CHANNELS(CHANNELS)) chk_u (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .port_dir(port_dir), .pin_oe_n(pin_oe_n)
);

`default_nettype wire

// file: sim/tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  import pwm8_pkg::*;
  // Design connections
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic [7:0] port_data, port_dir, pins, oe_n;
  logic clear, err_v;
  logic [7:0][19:0] charge;
  // Bookkeeping
  int mismatches, check_count;
  // Duty per channel; mix of edges, extremes and odd values
  logic [7:0] duty [8] = '{8'h00, 8'h01, 8'h10, 8'h7f, 8'h80, 8'hff, 8'h35, 8'hc9};
  logic [7:0] rst_val [6] = '{SEL_FIXED_READ, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] INV = 8'ha4;

  // Free-running bus clock, 50 ns
  always #25 pclk = ~pclk;

  pwm8_timer #(.CHANNELS(8)) dut_u (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port_data(port_data), .port_dir(port_dir),
    .pulse_output_pins(pins), .pin_oe_n(oe_n)
  );

  // One filter per pin
  for (genvar i = 0; i < 8; i++) begin : g_lpf
    lpf_model lpf_u (.clk(pclk), .rst_n(presetn), .pin(pins[i]), .clear(clear),
      .charge(charge[i]));
  end

  // Single comparison helper
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; entered just after a rising edge, leaves after one
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for the answer however long it takes; the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, {24'h000000, d});
  endtask

  task automatic rd(input string what, input logic [7:0] a, input logic [7:0] exp, input logic e);
    xfer(1'b0, a, 32'h00000000);
    check(what, {24'h000000, exp}, rd_v);
    check("pslverr", {31'h0, e}, {31'h0, err_v});
  endtask

  // Integrate every pin over a whole number of periods and compare
  task automatic measure(input int cycles, input bit stopped);
    logic [19:0] act;
    // Let the prescaler reach its first tick before the window opens
    repeat (32) @(posedge pclk);
    clear <= 1'b1;
    @(posedge pclk);
    clear <= 1'b0;
    repeat (cycles) @(posedge pclk);
    #1;
    for (int i = 0; i < 8; i++) begin
      act = stopped ? ((duty[i][7:4] != 4'h0) ? 20'(cycles) : 20'h00000)
                    : 20'(duty[i] * cycles / 256);
      if (INV[i]) act = 20'(cycles) - act;
      check("charge", {12'h000, act}, {12'h000, charge[i]});
    end
    @(posedge pclk);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Watchdog well beyond the roughly 9k cycles the tests need
  initial begin
    repeat (40000) @(posedge pclk);
    mismatches++;
    stop_test();
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    port_data = 8'h00;
    port_dir = 8'hff;
    clear = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rst_val[i]) rd("reset value", 8'(i * 4), rst_val[i], 1'b0);
    wr(OFF_SELECT, 8'h17);
    rd("fixed bits", OFF_SELECT, 8'h27, 1'b0);
    for (int i = 0; i < 8; i++) begin
      wr(OFF_SELECT, 8'(i));
      wr(OFF_DUTY, duty[i]);
    end
    for (int i = 0; i < 8; i++) begin
      wr(OFF_SELECT, 8'(i));
      rd("duty", OFF_DUTY, duty[i], 1'b0);
    end
    // Top select bit set: no channel behind the data port
    wr(OFF_SELECT, 8'h0b);
    wr(OFF_DUTY, 8'haa);
    rd("no channel", OFF_DUTY, 8'h00, 1'b0);
    wr(OFF_SELECT, 8'h00);
    rd("channel kept", OFF_DUTY, duty[0], 1'b0);
    rd("unmapped", 8'h18, 8'h00, 1'b1);
    wr(8'h18, 8'h55);
    check("write error", 32'h1, {31'h0, err_v});
    // Clock choice is locked while flash access is enabled
    wr(OFF_STC, 8'h08);
    wr(OFF_PCLK, 8'h0e);
    rd("locked choice", OFF_PCLK, 8'h00, 1'b0);
    wr(OFF_STC, 8'h00);
    wr(OFF_PCLK, 8'hff);
    rd("clock choice", OFF_PCLK, 8'h0e, 1'b0);
    wr(OFF_PCLK, 8'h00);
    wr(OFF_POLARITY, INV);
    wr(OFF_OUT_EN, 8'hff);
    rd("polarity", OFF_POLARITY, INV, 1'b0);
    measure(256, 1'b1);
    // Rates phi to phi/16; window scales with the division
    for (int k = 0; k < 5; k++) begin
      wr(OFF_PCLK, 8'(k * 2));
      wr(OFF_SELECT, 8'h80);
      measure(256 << k, 1'b0);
      wr(OFF_SELECT, 8'h00);
    end
    // Disabled channels fall back to port data
    wr(OFF_SELECT, 8'h80);
    wr(OFF_OUT_EN, 8'h0f);
    port_data <= 8'h5a;
    repeat (3) @(posedge pclk);
    #1;
    check("port pins", 32'h5, {28'h0, pins[7:4]});
    @(posedge pclk);
    port_dir <= 8'hc3;
    repeat (3) @(posedge pclk);
    #1;
    check("pin enable", 32'h3c, {24'h0, oe_n});
    // A low clock enable freezes pins and waveform, port data included
    @(posedge pclk);
    ce <= 1'b0;
    port_data <= 8'ha5;
    @(posedge pclk);
    #1;
    rd_v = {24'h0, pins};
    repeat (8) @(posedge pclk);
    #1;
    check("frozen pins", rd_v, {24'h0, pins});
    @(posedge pclk);
    ce <= 1'b1;
    repeat (3) @(posedge pclk);
    #1;
    check("thawed pins", 32'ha, {28'h0, pins[7:4]});
    stop_test();
  end
endmodule // tb_top

`default_nettype wire
